// ==== smb_core.sv ====
// smb_core: full-duplex serial port, master or slave, normal or enhanced
// (one-byte write buffer), with its registers on an AHB-Lite slave.
// assumes clk is the oscillator; pins are split into in/out/enable.
// Function
// (RULE_01) master drives the serial clock; slave takes it as input
// (RULE_02) master select sets data pin directions
// (RULE_03) master ignores slave select
// (RULE_04) slave works only while select is low; high frees its pins
// (RULE_05) normal-mode master write starts clock and sends the byte
// (RULE_06) first bit may wait for the next bit slot boundary
// (RULE_07) after one byte: clock stops, done flag set, byte to read buffer
// (RULE_08) interrupt needs done, port enable and shared serial enable; code gates with the irq enable bit instead of port enable
// (RULE_09) data address reads receive buffer, writes transmit path
// (RULE_10) normal mode write while busy sets collision, is dropped
// (RULE_11) enhanced write fills buffer, sets full flag, overwrites
// (RULE_12) full flag clears when buffer moves into shift register
// (RULE_13) enhanced write to idle master starts at once, flag clears
// (RULE_14) load window flag high for first four bits of a byte
// (RULE_15) software checks load window set and full clear first
// (RULE_16) full flag at byte end reloads and keeps clocking
// (RULE_17) port enable connects the serial pins
// (RULE_18) bit order one sends LSB first, zero MSB first
// (RULE_19) master select one gives master mode, zero slave
// (RULE_20) clock polarity sets the idle level of the clock
// (RULE_21) bit rate at most f/4, or f/2 with doubled clock
// (RULE_22) control resets to 04 with documented field order
// (RULE_23) rate bits divide by 4, 16, 64, 128; halve in x2
// (RULE_24) done and collision clear on status read then data access
// (RULE_25) slave select rising mid byte aborts and resets bit count
`timescale 1ns/1ps
module smb_core
    import smb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial clock pin
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    // master-out data pin
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    // master-in data pin
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    // slave select pin
    input wire logic ssN,
    // transfer interrupt request
    output logic irq
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] aux;
        logic dso;
        logic enh;
        logic done;
        logic write_collision_flag;
        logic armed;
        logic [7:0] txBuf;
        logic [7:0] sh;
        logic [7:0] rxBuf;
        logic rxBit;
        logic outBit;
        logic busy;
        logic [3:0] bitCnt;
        logic sckLvl;
        logic sckPrev;
        logic [31:0] hrdata;
        logic aValid;
        logic aWrite;
        logic [31:0] aAddr;
        logic rdy;
        logic irq;
        logic sckOut;
        logic sckOe;
        logic mosiOe;
        logic misoOe;
    } smb_core_t;

    smb_core_t s, n;
    logic [3:0] pinSync;
    logic sckS, mosiS, misoS, ssS;
    logic tick;
    logic master, pen, lsb, clock_phase, clock_polarity, enh, selected;
    logic take, rdStat, rdData, wrData, idle, load_window_flag;
    logic lead, trail, din, byteDone, slvEdge;
    logic [7:0] nextSh;

    // every pin input is synchronised before use
    smb_sync #(.W(4)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .din({sckIn, mosiIn, misoIn, ssN}),
        .dout(pinSync)
    );
    assign {sckS, mosiS, misoS, ssS} = pinSync;

    smb_rate u_rate (
        .clk(clk),
        .nrst(nrst),
        .run(master & pen),
        .rate(s.ctrl[CTRL_RATE_HI:CTRL_RATE_LO]), // RULE_23
        .x2(s.aux[AUX_X2]), // RULE_21
        .tick(tick)
    );

    // control field decode
    assign master = s.ctrl[CTRL_MASTER_SELECT]; // RULE_19
    assign pen = s.ctrl[CTRL_PEN];
    assign lsb = s.ctrl[CTRL_ORDER]; // RULE_18
    assign clock_phase = s.ctrl[CTRL_CLOCK_PHASE];
    assign clock_polarity = s.ctrl[CTRL_CLOCK_POLARITY];
    assign enh = s.enh;
    assign selected = !master && pen && !ssS; // RULE_04
    assign idle = master ? !s.busy : (s.bitCnt == 4'h0);
    assign load_window_flag = !idle && (s.bitCnt < LOAD_WINDOW_FLAG_BITS); // RULE_14

    // bus phases: reads answer from the address phase, writes land
    // in the data phase; zero wait states throughout
    assign take = hsel && htrans[1] && hready;
    assign rdStat = take && !hwrite && (haddr == ADDR_STAT);
    assign rdData = take && !hwrite && (haddr == ADDR_DATA);
    assign wrData = s.aValid && s.aWrite && (s.aAddr == ADDR_DATA);

    // shift events; the master ignores the select pin entirely
    assign slvEdge = selected && (sckS != s.sckPrev);
    assign lead = master ? (s.busy && tick && !s.sckLvl) // RULE_03
                         : (slvEdge && (sckS != clock_polarity));
    assign trail = master ? (s.busy && tick && s.sckLvl)
                          : (slvEdge && (sckS == clock_polarity));
    assign din = master ? misoS : mosiS; // RULE_02
    assign byteDone = trail && (s.bitCnt == BYTE_BITS - 4'h1);
    assign nextSh = shiftIn(s.sh, lsb, clock_phase ? din : s.rxBit);

    always_comb begin
        n = s;
        n.rdy = 1'b1;
        n.sckPrev = sckS;
        n.aValid = take;
        n.aWrite = hwrite;
        n.aAddr = haddr;

        // read data registered at the address phase
        n.hrdata = 32'h0;
        if (take && !hwrite) begin
            if (haddr == ADDR_CTRL) begin
                n.hrdata = {24'h0, s.ctrl};
            end else if (haddr == ADDR_STAT) begin
                n.hrdata = {24'h0, s.done, s.write_collision_flag, load_window_flag, 3'h0,
                            s.dso, s.enh};
            end else if (haddr == ADDR_DATA) begin
                n.hrdata = {24'h0, s.rxBuf}; // RULE_09
            end else if (haddr == ADDR_AUX) begin
                n.hrdata = {24'h0, s.aux};
            end
        end

        // register writes; unmapped addresses are ignored
        if (s.aValid && s.aWrite) begin
            if (s.aAddr == ADDR_CTRL) begin
                n.ctrl = hwdata[7:0];
            end else if (s.aAddr == ADDR_STAT) begin
                n.dso = hwdata[STAT_DSO];
                n.enh = hwdata[STAT_ENH];
            end else if (s.aAddr == ADDR_AUX) begin
                n.aux = hwdata[7:0];
            end
        end

        // status read arms the clear; the next data access fires it.
        // placed before the setters so a same-cycle set wins
        if (s.armed && (rdData || wrData)) begin
            n.done = 1'b0; // RULE_24
            if (!enh) begin
                n.write_collision_flag = 1'b0; // RULE_24
            end
        end
        if (rdData || wrData) begin
            n.armed = 1'b0;
        end
        if (rdStat) begin
            n.armed = 1'b1;
        end

        // data write: straight to shifter or into the buffer
        if (wrData) begin
            if (enh) begin
                n.txBuf = hwdata[7:0]; // RULE_11
                n.write_collision_flag = 1'b1; // RULE_11
            end else if (!idle) begin
                n.write_collision_flag = 1'b1; // RULE_10
            end else begin
                n.sh = hwdata[7:0];
                n.outBit = curBit(hwdata[7:0], lsb);
                if (master && pen) begin
                    n.busy = 1'b1; // RULE_05
                    n.bitCnt = 4'h0;
                    n.sckLvl = 1'b0;
                end
            end
        end

        // enhanced mode: a buffered byte with the engine idle starts
        // on the next cycle
        if (enh && s.write_collision_flag && idle && (master ? pen : !slvEdge)) begin
            n.sh = s.txBuf; // RULE_12
            n.outBit = curBit(s.txBuf, lsb);
            n.write_collision_flag = wrData; // RULE_13
            if (wrData) begin
                n.txBuf = hwdata[7:0];
            end
            if (master) begin
                n.busy = 1'b1; // RULE_13
                n.bitCnt = 4'h0;
                n.sckLvl = 1'b0;
            end
        end

        // master clock level toggles each half slot
        if (master && s.busy && tick) begin
            n.sckLvl = !s.sckLvl; // RULE_06
        end

        // leading edge: phase one presents, phase zero samples
        if (lead) begin
            if (clock_phase) begin
                n.outBit = curBit(s.sh, lsb);
            end else begin
                n.rxBit = din;
            end
        end

        // trailing edge: shift, and at the eighth bit finish the byte
        if (trail) begin
            n.sh = nextSh;
            n.bitCnt = s.bitCnt + 4'h1;
            if (!clock_phase) begin
                n.outBit = curBit(nextSh, lsb);
            end
            if (byteDone) begin
                n.rxBuf = nextSh; // RULE_07
                n.done = 1'b1; // RULE_07
                n.bitCnt = 4'h0;
                if (enh && s.write_collision_flag) begin
                    n.sh = s.txBuf; // RULE_16
                    n.outBit = curBit(s.txBuf, lsb);
                    n.write_collision_flag = wrData; // RULE_16
                end else if (master) begin
                    n.busy = 1'b0; // RULE_07
                end
            end
        end

        // leaving master mode or disabling stops the generator
        if (!(master && pen)) begin
            n.busy = 1'b0;
            n.sckLvl = 1'b0;
        end
        // deselected slave drops a partial byte
        if (!master && !selected) begin
            n.bitCnt = 4'h0; // RULE_25
        end

        // pin drive and interrupt, all registered
        // new polarity shows at once, so no stale idle level after a write
        n.sckOut = n.ctrl[CTRL_CLOCK_POLARITY] ^ n.sckLvl; // RULE_20
        n.sckOe = pen && master; // RULE_01
        n.mosiOe = pen && master; // RULE_17
        n.misoOe = selected && !s.dso; // RULE_02
        n.irq = n.ctrl[CTRL_IRQEN] && n.aux[AUX_SERIRQ] && n.done; // RULE_08
    end

    // control register resets to its documented value
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '{ctrl: RST_CTRL, aux: RST_AUX, rdy: 1'b1, // RULE_22
                   default: '0};
        end else begin
            s <= n;
        end
    end

    // outputs straight from the state register, except hresp, which is tied low
    assign hrdata = s.hrdata;
    assign hreadyout = s.rdy;
    assign hresp = 1'b0;
    assign sckOut = s.sckOut;
    assign sckOe = s.sckOe;
    assign mosiOut = s.outBit;
    assign mosiOe = s.mosiOe;
    assign misoOut = s.outBit;
    assign misoOe = s.misoOe;
    assign irq = s.irq;

    property p_done_set;
        @(posedge clk) disable iff (!nrst)
        (master && byteDone) |=> s.done;
    endproperty
    a_done_set: assert property (p_done_set) // RULE_07
        else $error("done flag not set after byte");

    property p_clock_stop;
        @(posedge clk) disable iff (!nrst)
        (master && byteDone && !(enh && s.write_collision_flag)) |=> !s.busy;
    endproperty
    a_clock_stop: assert property (p_clock_stop) // RULE_07
        else $error("clock generator kept running");

    property p_continue;
        @(posedge clk) disable iff (!nrst)
        (master && pen && byteDone && enh && s.write_collision_flag && !wrData)
            |=> (s.busy && !s.write_collision_flag && s.bitCnt == 4'h0);
    endproperty
    a_continue: assert property (p_continue) // RULE_16
        else $error("buffered byte not chained");

    property p_idle_start;
        @(posedge clk) disable iff (!nrst)
        (enh && s.write_collision_flag && master && pen && !s.busy && !wrData)
            |=> (s.busy && !s.write_collision_flag);
    endproperty
    a_idle_start: assert property (p_idle_start) // RULE_13
        else $error("idle master did not start buffered byte");

    property p_collision;
        @(posedge clk) disable iff (!nrst)
        (wrData && !enh && master && s.busy) |=> (s.write_collision_flag && s.busy);
    endproperty
    a_collision: assert property (p_collision) // RULE_10
        else $error("collision not flagged");

    property p_load_window_flag;
        @(posedge clk) disable iff (!nrst)
        (rdStat && master && s.busy)
            |=> (s.hrdata[STAT_LOAD_WINDOW_FLAG] == ($past(s.bitCnt) < LOAD_WINDOW_FLAG_BITS));
    endproperty
    a_load_window_flag: assert property (p_load_window_flag) // RULE_14
        else $error("load window flag wrong");

    property p_irq;
        @(posedge clk) disable iff (!nrst)
        s.irq == (s.done && s.ctrl[CTRL_IRQEN] && s.aux[AUX_SERIRQ]);
    endproperty
    a_irq: assert property (p_irq) // RULE_08
        else $error("interrupt does not follow its enables");

    property p_sck_idle;
        @(posedge clk) disable iff (!nrst)
        (master && pen && !s.busy && !wrData)[*2] |-> (sckOut == clock_polarity);
    endproperty
    a_sck_idle: assert property (p_sck_idle) // RULE_20
        else $error("serial clock not at idle level");

    property p_slave_abort;
        @(posedge clk) disable iff (!nrst)
        (!master && ssS) |=> (s.bitCnt == 4'h0 && !misoOe);
    endproperty
    a_slave_abort: assert property (p_slave_abort) // RULE_25
        else $error("deselected slave kept bit count");

    property p_sck_dir;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> (sckOe == $past(pen && master));
    endproperty
    a_sck_dir: assert property (p_sck_dir) // RULE_01
        else $error("serial clock direction wrong");
endmodule

// ==== smb_peer.sv ====
// smb_peer: behavioural serial slave facing the port in master mode.
// assumes clock phase 0; polarity, order and pace are set by the bench.
`timescale 1ns/1ps
module smb_peer (
    // pin levels
    input wire logic sck,
    input wire logic mosi,
    input wire logic selN,
    // setup from the bench
    input wire logic clock_polarity,
    input wire logic lsbFirst,
    input wire logic slow,
    input wire logic [7:0] txByte,
    // results
    output logic miso,
    output logic [7:0] rxLast
);
    logic [7:0] sh = 8'h00;
    logic [7:0] rx = 8'h00;
    int bitNum = 0;
    initial miso = 1'h0;
    // select loads a byte; a released line must not keep its last level
    always @(selN) begin
        bitNum = 0;
        sh = txByte;
        if (selN === 1'h0) begin
            miso <= #(slow ? 300 : 0) (lsbFirst ? sh[0] : sh[7]);
        end else begin
            miso <= ~miso;
        end
    end
    // leading edge samples mosi, trailing edge presents the next bit
    always @(sck) begin
        if (selN === 1'h0 && sck === ~clock_polarity) begin
            rx = lsbFirst ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            bitNum++;
            if (bitNum == 8) begin
                rxLast = rx;
            end
        end else if (selN === 1'h0) begin
            sh = (bitNum == 8) ? txByte : (lsbFirst ? sh >> 1 : sh << 1);
            bitNum = bitNum % 8;
            miso <= #(slow ? 300 : 0) (lsbFirst ? sh[0] : sh[7]);
        end
    end
endmodule

// ==== smb_pkg.sv ====
// smb_pkg: register map, field positions, reset values and rate limits
// for the buffered serial peripheral port; shared by the core, the rate generator and the bench.
// assumes a 32-bit AHB-Lite register bus, one register per aligned word.
package smb_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'hd5;
    localparam logic [7:0] IDX_STAT = 8'haa;
    localparam logic [7:0] IDX_DATA = 8'h86;
    localparam logic [7:0] IDX_AUX = 8'hf0;
    localparam logic [31:0] ADDR_CTRL = {22'h0, IDX_CTRL, 2'b00};
    localparam logic [31:0] ADDR_STAT = {22'h0, IDX_STAT, 2'b00};
    localparam logic [31:0] ADDR_DATA = {22'h0, IDX_DATA, 2'b00};
    localparam logic [31:0] ADDR_AUX = {22'h0, IDX_AUX, 2'b00};

    // port_control_reg fields
    localparam int CTRL_IRQEN = 7;
    localparam int CTRL_PEN = 6;
    localparam int CTRL_ORDER = 5;
    localparam int CTRL_MASTER_SELECT = 4;
    localparam int CTRL_CLOCK_POLARITY = 3;
    localparam int CTRL_CLOCK_PHASE = 2;
    localparam int CTRL_RATE_HI = 1;
    localparam int CTRL_RATE_LO = 0;
    localparam logic [7:0] RST_CTRL = 8'h04;

    // port_status_reg fields
    localparam int STAT_DONE = 7;
    localparam int STAT_WRITE_COLLISION_FLAG = 6;
    localparam int STAT_LOAD_WINDOW_FLAG = 5;
    localparam int STAT_DSO = 1;
    localparam int STAT_ENH = 0;

    // auxiliary register: shared serial irq enable and doubled clock
    localparam int AUX_SERIRQ = 0;
    localparam int AUX_X2 = 1;
    localparam logic [7:0] RST_AUX = 8'h00;

    // oscillator divisors per rate code, and byte timing
    localparam int DIV_R0 = 4;
    localparam int DIV_R1 = 16;
    localparam int DIV_R2 = 64;
    localparam int DIV_R3 = 128;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LOAD_WINDOW_FLAG_BITS = 4'h4;

    // half bit period minus one, in clk cycles
    function automatic logic [5:0] halfLimit(input logic [1:0] rate,
                                             input logic x2);
        int div;
        div = (rate == 2'h0) ? DIV_R0 : (rate == 2'h1) ? DIV_R1 :
              (rate == 2'h2) ? DIV_R2 : DIV_R3;
        if (x2) begin
            div = div / 2;
        end
        halfLimit = 6'(div / 2 - 1);
    endfunction

    // bit presented on the data line for the given bit order
    function automatic logic curBit(input logic [7:0] sh,
                                    input logic lsbFirst);
        curBit = lsbFirst ? sh[0] : sh[7];
    endfunction

    // shift one received bit in, pushing the sent bit out
    function automatic logic [7:0] shiftIn(input logic [7:0] sh,
                                           input logic lsbFirst,
                                           input logic din);
        shiftIn = lsbFirst ? {din, sh[7:1]} : {sh[6:0], din};
    endfunction

endpackage

// ==== smb_rate.sv ====
// smb_rate: free-running half-bit tick for the master clock generator.
// assumes run stays high while the port is an enabled master.
`timescale 1ns/1ps
module smb_rate
    import smb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // rate selection
    input wire logic run,
    input wire logic [1:0] rate,
    input wire logic x2,
    // one-cycle pulse per half bit slot
    output logic tick
);
    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } smb_rate_t;

    smb_rate_t s, n;
    logic [5:0] lim;

    // free running, so a new byte waits for the next slot boundary
    always_comb begin
        n = s;
        lim = halfLimit(rate, x2);
        n.tick = 1'b0;
        if (!run) begin
            n.cnt = 6'h00;
        end else if (s.cnt >= lim) begin
            n.cnt = 6'h00;
            n.tick = 1'b1;
        end else begin
            n.cnt = s.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tick = s.tick;
endmodule

// ==== smb_sync.sv ====
// smb_sync: two-flop synchroniser for the port's input pins.
// assumes inputs arrive from outside the clk domain.
`timescale 1ns/1ps
module smb_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // raw and synchronised levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } smb_sync_t;

    smb_sync_t s, n;

    // the first stage feeds only the second stage
    always_comb begin
        n = s;
        n.meta = din;
        n.stable = s.meta;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign dout = s.stable;
endmodule

// ==== tb.sv ====
// tb: register-level bench for the serial port, with a slave peer.
// assumes zero-wait bus answers; the bench is master in slave tests.
`timescale 1ns/1ps
module tb;
    import smb_pkg::*;
    // clock, reset, bus
    logic clk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, irq;
    // pins, bench drivers, peer setup
    logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, pMiso;
    logic tbSck = 1'h0, tbMosi = 1'h0, ssN = 1'h1, pSelN = 1'h1;
    logic pCpol = 1'h0, pLsb = 1'h0, pSlow = 1'h0;
    logic [7:0] pTx = 8'h00, pRx, got;
    logic sckLine, mosiLine, misoLine;
    int err_total = 0, checked = 0, cyc = 0, edges = 0, lastEdge = 0;
    int gap = 0;
    int divTab[4] = '{4, 16, 64, 128};

    always #50 clk = ~clk;
    always @(posedge clk) cyc++;
    // wire levels from whichever party enables its driver
    assign sckLine = sckOe ? sckOut : tbSck;
    assign mosiLine = mosiOe ? mosiOut : tbMosi;
    assign misoLine = misoOe ? misoOut : pMiso;
    // serial clock monitor: rising-edge count and widest gap between rising edges
    always @(posedge sckOut) begin
        if (edges > 0 && cyc - lastEdge > gap) begin
            gap = cyc - lastEdge;
        end
        lastEdge = cyc;
        edges++;
    end

    smb_core i_dut (
        .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe),
        .mosiIn(mosiLine), .mosiOut(mosiOut), .mosiOe(mosiOe),
        .misoIn(misoLine), .misoOut(misoOut), .misoOe(misoOe),
        .ssN(ssN), .irq(irq)
    );
    smb_peer i_peer (
        .sck(sckLine), .mosi(mosiLine), .selN(pSelN), .clock_polarity(pCpol),
        .lsbFirst(pLsb), .slow(pSlow), .txByte(pTx), .miso(pMiso),
        .rxLast(pRx)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one single transfer; entered just after a rising edge
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do begin @(posedge clk); n++; end
        while (hreadyout !== 1'h1 && n < 20);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge clk); n++; end
        while (hreadyout !== 1'h1 && n < 40);
        rd = hrdata;
        if (n >= 40) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'h1, d);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e,
                       input string nm);
        bus(a, 1'h0, 32'h0);
        chk(nm, e, rd);
    endtask
    // status polling arms the flag clear; a bounded wait for done
    task automatic waitDone();
        int n;
        n = 0;
        do begin bus(ADDR_STAT, 1'h0, 32'h0); n++; end
        while (rd[STAT_DONE] !== 1'h1 && n < 600);
        if (n >= 600) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic waitEdges(input int k);
        for (int n = 0; n < 3000 && edges < k; n++) @(posedge clk);
        if (edges < k) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic start();
        @(posedge clk);
        edges = 0;
        gap = 0;
    endtask
    // bench as master, mode 0, msb first, 8 clk half periods
    task automatic xfer(input logic [7:0] b, input int n);
        got = 8'h00;
        for (int k = 0; k < n; k++) begin
            tbMosi <= b[7 - k];
            repeat (8) @(posedge clk);
            tbSck <= 1'h1;
            got = {got[6:0], misoOut};
            repeat (8) @(posedge clk);
            tbSck <= 1'h0;
        end
        repeat (8) @(posedge clk);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'h1;
        // reset values, control access, unmapped place, port off
        rdc(ADDR_CTRL, 32'h04, "ctrl");
        chk("hresp", 1'h0, hresp);
        rdc(ADDR_STAT, 32'h00, "stat");
        rdc(32'h0000_0004, 32'h00, "unmapped");
        wr(ADDR_CTRL, 32'hffff_ffab);
        rdc(ADDR_CTRL, 32'hab, "ctrl rw");
        ssN <= 1'h0;
        repeat (4) @(posedge clk);
        chk("pins off", 3'h0, {sckOe, mosiOe, misoOe});
        // normal master byte with a collision; select pin left high
        ssN <= 1'h1;
        wr(ADDR_CTRL, 32'hd1);
        repeat (2) @(posedge clk);
        chk("mst", 4'hc, {sckOe, mosiOe, misoOe, sckOut});
        pTx <= 8'h3c;
        pSelN <= 1'h0;
        start();
        wr(ADDR_DATA, 32'ha5);
        wr(ADDR_DATA, 32'h11);
        waitDone();
        chk("flags", 2'h3, rd[7:6]);
        chk("edges", 32'h8, edges);
        chk("period", 32'h10, gap);
        chk("irq off", 1'h0, irq);
        wr(ADDR_AUX, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq on", 1'h1, irq);
        wr(ADDR_CTRL, 32'h51);
        repeat (2) @(posedge clk);
        chk("irq masked", 1'h0, irq);
        bus(ADDR_STAT, 1'h0, 32'h0);
        rdc(ADDR_DATA, 32'h3c, "rx");
        rdc(ADDR_STAT, 32'h00, "cleared");
        chk("peer rx", 8'ha5, pRx);
        // each rate code, plain and doubled, both orders and polarities
        for (int i = 0; i < 8; i++) begin
            pSelN <= 1'h1;
            pLsb <= i[0];
            pCpol <= i[1];
            wr(ADDR_AUX, {30'h0, i[2], 1'h0});
            wr(ADDR_CTRL, {24'h0, 2'h1, i[0], 1'h1, i[1], 1'h0, i[1:0]});
            repeat (2) @(posedge clk);
            chk("idle", {31'h0, i[1]}, {31'h0, sckOut});
            pSelN <= 1'h0;
            start();
            wr(ADDR_DATA, {24'h0, 3'(i), 5'h0b});
            waitDone();
            chk("period", 32'(divTab[i % 4] >> i[2]), gap);
            chk("peer rx", {3'(i), 5'h0b}, pRx);
            bus(ADDR_DATA, 1'h0, 32'h0);
        end
        // enhanced mode: buffered bytes keep the clock running
        pSelN <= 1'h1;
        pCpol <= 1'h0;
        pLsb <= 1'h0;
        pSlow <= 1'h1;
        wr(ADDR_AUX, 32'h0);
        wr(ADDR_CTRL, 32'h51);
        wr(ADDR_STAT, 32'h1);
        pTx <= 8'he7;
        pSelN <= 1'h0;
        start();
        wr(ADDR_DATA, 32'h61);
        pTx <= 8'h5e;
        waitEdges(1);
        rdc(ADDR_STAT, 32'h21, "first load");
        if (rd[5] === 1'h1 && rd[6] === 1'h0) begin
            wr(ADDR_DATA, 32'h62);
        end
        rdc(ADDR_STAT, 32'h61, "buffer full");
        wr(ADDR_DATA, 32'h63);
        waitEdges(5);
        rdc(ADDR_STAT, 32'h41, "late bits");
        waitEdges(9);
        bus(ADDR_STAT, 1'h0, 32'h0);
        chk("reloaded", 2'h1, rd[6:5]);
        rdc(ADDR_DATA, 32'he7, "enh rx");
        waitDone();
        chk("no pause", 32'h10, gap);
        chk("edges", 32'h10, edges);
        rdc(ADDR_DATA, 32'h5e, "enh rx2");
        chk("peer rx2", 8'h63, pRx);
        // slave mode with the bench as master, then an aborted byte
        pSelN <= 1'h1;
        wr(ADDR_STAT, 32'h0);
        wr(ADDR_CTRL, 32'h40);
        repeat (2) @(posedge clk);
        chk("deselected", 3'h0, {sckOe, mosiOe, misoOe});
        wr(ADDR_DATA, 32'h96);
        ssN <= 1'h0;
        repeat (4) @(posedge clk);
        chk("selected", 3'h1, {sckOe, mosiOe, misoOe});
        xfer(8'h5a, 8);
        chk("slave tx", 8'h96, got);
        bus(ADDR_STAT, 1'h0, 32'h0);
        rdc(ADDR_DATA, 32'h5a, "slave rx");
        xfer(8'h0f, 3);
        ssN <= 1'h1;
        repeat (4) @(posedge clk);
        ssN <= 1'h0;
        repeat (4) @(posedge clk);
        xfer(8'hc3, 8);
        bus(ADDR_STAT, 1'h0, 32'h0);
        chk("abort done", 1'h1, rd[7]);
        rdc(ADDR_DATA, 32'hc3, "after abort");
        complete_run();
    end
endmodule
